//--- design/pcr_pkg.sv
// ----------------------------------------------------------------
// pll configuration register bank constants
// ----------------------------------------------------------------
package pcr_pkg;

    // byte offsets of the bank
    localparam logic [7:0] PCR_OFF_FB3_LOW   = 8'h04;
    localparam logic [7:0] PCR_OFF_FILT3     = 8'h05;
    localparam logic [7:0] PCR_OFF_PUMP3     = 8'h06;
    localparam logic [7:0] PCR_OFF_CTRL1     = 8'h07;
    localparam logic [7:0] PCR_OFF_REF1      = 8'h08;
    localparam logic [7:0] PCR_OFF_FB1_LOW   = 8'h09;
    localparam logic [7:0] PCR_OFF_FILT1     = 8'h0a;
    localparam logic [7:0] PCR_OFF_PUMP1     = 8'h0b;
    localparam logic [7:0] PCR_OFF_SS_REF1   = 8'h0c;
    localparam logic [7:0] PCR_OFF_SS_FB1_HI = 8'h0d;
    localparam logic [7:0] PCR_OFF_SS_FB1_LO = 8'h0e;
    localparam int         PCR_FIRST         = 4;
    localparam int         PCR_LAST          = 14;

    // power-up values, lowest offset first
    localparam logic [7:0] PCR_DEFAULTS [PCR_FIRST:PCR_LAST] = '{
        8'he0, 8'h11, 8'h6c, 8'h23, 8'h19, 8'h58,
        8'hb2, 8'h06, 8'h00, 8'h00, 8'h00};

    // field positions shared by both loop filter bytes
    localparam int PCR_B_RES_A    = 7;
    localparam int PCR_B_RES_B    = 6;
    localparam int PCR_B_RES_C    = 5;
    localparam int PCR_B_RES_D    = 4;
    localparam int PCR_B_RES_ONLY = 3;
    localparam int PCR_B_FB_HI_MSB = 2;

    // third pll pump byte
    localparam int PCR_B_OUT3_SRC = 7;
    localparam int PCR_B_P3_W8    = 6;
    localparam int PCR_B_P3_W1    = 3;
    localparam int PCR_B_P3_D24   = 2;
    localparam int PCR_B_P3_D3    = 1;
    localparam int PCR_B_P3_REF_CURRENT_BIT = 0;

    // first pll control byte
    localparam int PCR_B_DOUBLER  = 7;
    localparam int PCR_B_P1_REF_CURRENT_BIT = 6;
    localparam int PCR_B_CH2_EN   = 5;
    localparam int PCR_B_POLE_EN  = 4;
    localparam int PCR_B_DIV5_MSB = 3;

    // first pll reference byte
    localparam int PCR_B_BYP_ONE  = 7;
    localparam int PCR_B_BYP_TWO  = 6;
    localparam int PCR_B_MDIV_MSB = 5;

    // first pll pump byte
    localparam int PCR_B_P1_W32   = 7;
    localparam int PCR_B_P1_W1    = 2;
    localparam int PCR_B_P1_D24   = 1;
    localparam int PCR_B_P1_D3    = 0;

    // spread reference byte
    localparam int PCR_B_SS_TOP   = 7;

    // pump divisor weights
    localparam logic [7:0] PCR_PUMP_DIV24 = 8'h18;
    localparam logic [7:0] PCR_PUMP_DIV3  = 8'h03;

endpackage

//--- design/pcr_bank.sv
`timescale 1ns/1ns
// Functional notes
// - 06h bit7 picks divider three clock source
// - 05h bits7-4 insert third loop resistors
// - 05h bit3 applies only third 6k resistor
// - 05h bits2-0 are third feedback bits 10-8
// - 06h bits6-1 weight third charge pump
// - 06h bit0 selects third reference current
// - 07h bit7 enables first doubler, default off
// - 07h bit6 selects first reference current
// - 07h bit5 enables channel two, default on
// - 07h bit4 enables third pole, default off
// - 07h bits3-0 divider five, default 0011
// - 08h bit7 selects first divide-by-one bypass
// - 08h bit6 selects first divide-by-two bypass
// - 08h bits5-0 first reference divider, default 25
// - first feedback divider from 09h/0Ah, default 600
// - 0Ah bits7-4 insert first loop resistors
// - 0Ah bit3 applies only first 1k resistor
// - 0Bh weights first pump, default x1 /24
// - 0Ch spread reference divider with top bit 7
// - 0Dh spread feedback divider high byte
// - 04h holds third feedback low byte
// - 0Eh holds spread feedback low byte
// - start address then auto-stepping byte transfers
module pcr_bank
    import pcr_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // byte port from the serial engine
    input  wire logic        i_addr_load,
    input  wire logic [7:0]  i_addr,
    input  wire logic        i_wr_en,
    input  wire logic [7:0]  i_wr_data,
    input  wire logic        i_rd_en,
    output logic             o_rd_valid,
    output logic      [7:0]  o_rd_data,
    output logic      [7:0]  o_reg_pointer,
    // third pll controls
    output logic      [3:0]  o_third_loop_res,
    output logic             o_third_loop_res_only,
    output logic      [10:0] o_third_feedback_divider,
    output logic             o_out_divider_three_src,
    output logic      [3:0]  o_third_pump_weights,
    output logic             o_third_pump_div24,
    output logic             o_third_pump_div3,
    output logic             o_third_ref_current_sel,
    output logic      [7:0]  o_third_pump_num,
    output logic      [7:0]  o_third_pump_den,
    // first pll controls
    output logic             o_first_ref_doubler,
    output logic             o_first_ref_current_sel,
    output logic             o_first_channel_two_en,
    output logic             o_first_third_pole_en,
    output logic      [3:0]  o_out_divider_five,
    output logic             o_first_ref_bypass_one,
    output logic             o_first_ref_bypass_two,
    output logic      [5:0]  o_first_ref_divider,
    output logic      [10:0] o_first_feedback_divider,
    output logic      [3:0]  o_first_loop_res,
    output logic             o_first_loop_res_only,
    output logic      [5:0]  o_first_pump_weights,
    output logic             o_first_pump_div24,
    output logic             o_first_pump_div3,
    output logic      [7:0]  o_first_pump_num,
    output logic      [7:0]  o_first_pump_den,
    output logic      [6:0]  o_first_spread_ref_div,
    output logic             o_first_spread_ref_top_bit,
    output logic      [15:0] o_first_spread_fb_div
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic in_bank(input logic [7:0] a);
        in_bank = (a >= 8'(PCR_FIRST)) && (a <= 8'(PCR_LAST));
    endfunction

    // pump multiplier in units of the reference current
    function automatic logic [7:0] pump_num(input logic [5:0] w, input logic ref_current_bit);
        logic [7:0] sum;
        sum = 8'(w);
        pump_num = ref_current_bit ? 8'(sum << 1) : sum;
    endfunction

    // pump divisor; zero means both divisor bits are clear
    function automatic logic [7:0] pump_den(input logic d24, input logic d3);
        pump_den = (d24 ? PCR_PUMP_DIV24 : 8'h00) + (d3 ? PCR_PUMP_DIV3 : 8'h00);
    endfunction

    // ----------------------------------------------------------------
    // register storage and address pointer
    // ----------------------------------------------------------------
    logic [7:0] bank_q [PCR_FIRST:PCR_LAST];
    logic [7:0] bank_d [PCR_FIRST:PCR_LAST];
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       rd_valid_q;
    logic       rd_valid_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] rd_mux;

    // a pointer load wins over a byte in the same cycle
    assign wr_go  = i_wr_en && !i_addr_load;
    assign rd_go  = i_rd_en && !i_addr_load && !i_wr_en;
    // bytes outside the bank read as zero and drop writes
    assign rd_mux = in_bank(ptr_q) ? bank_q[ptr_q] : 8'h00;

    // next state of pointer, read answer and bank
    always_comb begin
        ptr_d      = ptr_q;
        rd_valid_d = 1'b0;
        rd_data_d  = rd_data_q;
        for (int i = PCR_FIRST; i <= PCR_LAST; i++) begin
            bank_d[i] = bank_q[i];
        end
        if (i_addr_load) begin
            ptr_d = i_addr;
        end else if (wr_go) begin
            for (int i = PCR_FIRST; i <= PCR_LAST; i++) begin
                if (ptr_q == 8'(i)) begin
                    bank_d[i] = i_wr_data;
                end
            end
            ptr_d = ptr_q + 8'h01;
        end else if (rd_go) begin
            rd_valid_d = 1'b1;
            rd_data_d  = rd_mux;
            ptr_d      = ptr_q + 8'h01;
        end
    end

    // registers; pointer wraps from ff back to 00 like a plain counter
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ptr_q      <= 8'h00;
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
            for (int i = PCR_FIRST; i <= PCR_LAST; i++) begin
                bank_q[i] <= PCR_DEFAULTS[i];
            end
        end else begin
            ptr_q      <= ptr_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
            for (int i = PCR_FIRST; i <= PCR_LAST; i++) begin
                bank_q[i] <= bank_d[i];
            end
        end
    end

    assign o_rd_valid    = rd_valid_q;
    assign o_rd_data     = rd_data_q;
    assign o_reg_pointer = ptr_q;

    // ----------------------------------------------------------------
    // pump weight products
    // ----------------------------------------------------------------
    logic [7:0] p3_num_q;
    logic [7:0] p3_num_d;
    logic [7:0] p3_den_q;
    logic [7:0] p3_den_d;
    logic [7:0] p1_num_q;
    logic [7:0] p1_num_d;
    logic [7:0] p1_den_q;
    logic [7:0] p1_den_d;

    // products trail the register byte by one clock to keep outputs on flops
    always_comb begin
        p3_num_d = pump_num({2'b00, bank_q[PCR_OFF_PUMP3][PCR_B_P3_W8:PCR_B_P3_W1]},
                            bank_q[PCR_OFF_PUMP3][PCR_B_P3_REF_CURRENT_BIT]);
        p3_den_d = pump_den(bank_q[PCR_OFF_PUMP3][PCR_B_P3_D24],
                            bank_q[PCR_OFF_PUMP3][PCR_B_P3_D3]);
        p1_num_d = pump_num(bank_q[PCR_OFF_PUMP1][PCR_B_P1_W32:PCR_B_P1_W1],
                            bank_q[PCR_OFF_CTRL1][PCR_B_P1_REF_CURRENT_BIT]);
        p1_den_d = pump_den(bank_q[PCR_OFF_PUMP1][PCR_B_P1_D24],
                            bank_q[PCR_OFF_PUMP1][PCR_B_P1_D3]);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            p3_num_q <= 8'h00;
            p3_den_q <= 8'h00;
            p1_num_q <= 8'h00;
            p1_den_q <= 8'h00;
        end else begin
            p3_num_q <= p3_num_d;
            p3_den_q <= p3_den_d;
            p1_num_q <= p1_num_d;
            p1_den_q <= p1_den_d;
        end
    end

    assign o_third_pump_num = p3_num_q;
    assign o_third_pump_den = p3_den_q;
    assign o_first_pump_num = p1_num_q;
    assign o_first_pump_den = p1_den_q;

    // ----------------------------------------------------------------
    // third pll fields
    // ----------------------------------------------------------------
    // series resistor segments
    assign o_third_loop_res = bank_q[PCR_OFF_FILT3][PCR_B_RES_A:PCR_B_RES_D];
    assign o_third_loop_res_only = bank_q[PCR_OFF_FILT3][PCR_B_RES_ONLY];
    assign o_third_feedback_divider = {bank_q[PCR_OFF_FILT3][PCR_B_FB_HI_MSB:0],
                                       bank_q[PCR_OFF_FB3_LOW]};
    assign o_out_divider_three_src = bank_q[PCR_OFF_PUMP3][PCR_B_OUT3_SRC];
    assign o_third_pump_weights = bank_q[PCR_OFF_PUMP3][PCR_B_P3_W8:PCR_B_P3_W1];
    assign o_third_pump_div24   = bank_q[PCR_OFF_PUMP3][PCR_B_P3_D24];
    assign o_third_pump_div3    = bank_q[PCR_OFF_PUMP3][PCR_B_P3_D3];
    assign o_third_ref_current_sel = bank_q[PCR_OFF_PUMP3][PCR_B_P3_REF_CURRENT_BIT];

    // ----------------------------------------------------------------
    // first pll fields
    // ----------------------------------------------------------------
    // doubler enable
    assign o_first_ref_doubler     = bank_q[PCR_OFF_CTRL1][PCR_B_DOUBLER];
    assign o_first_ref_current_sel = bank_q[PCR_OFF_CTRL1][PCR_B_P1_REF_CURRENT_BIT];
    assign o_first_channel_two_en  = bank_q[PCR_OFF_CTRL1][PCR_B_CH2_EN];
    assign o_first_third_pole_en   = bank_q[PCR_OFF_CTRL1][PCR_B_POLE_EN];
    assign o_out_divider_five      = bank_q[PCR_OFF_CTRL1][PCR_B_DIV5_MSB:0];
    assign o_first_ref_bypass_one  = bank_q[PCR_OFF_REF1][PCR_B_BYP_ONE];
    assign o_first_ref_bypass_two  = bank_q[PCR_OFF_REF1][PCR_B_BYP_TWO];
    // reference divider; range is not policed, software owns it
    assign o_first_ref_divider     = bank_q[PCR_OFF_REF1][PCR_B_MDIV_MSB:0];
    assign o_first_feedback_divider = {bank_q[PCR_OFF_FILT1][PCR_B_FB_HI_MSB:0],
                                       bank_q[PCR_OFF_FB1_LOW]};
    assign o_first_loop_res      = bank_q[PCR_OFF_FILT1][PCR_B_RES_A:PCR_B_RES_D];
    assign o_first_loop_res_only = bank_q[PCR_OFF_FILT1][PCR_B_RES_ONLY];
    assign o_first_pump_weights  = bank_q[PCR_OFF_PUMP1][PCR_B_P1_W32:PCR_B_P1_W1];
    assign o_first_pump_div24    = bank_q[PCR_OFF_PUMP1][PCR_B_P1_D24];
    assign o_first_pump_div3     = bank_q[PCR_OFF_PUMP1][PCR_B_P1_D3];
    assign o_first_spread_ref_div     = bank_q[PCR_OFF_SS_REF1][PCR_B_SS_TOP-1:0];
    assign o_first_spread_ref_top_bit = bank_q[PCR_OFF_SS_REF1][PCR_B_SS_TOP];
    assign o_first_spread_fb_div = {bank_q[PCR_OFF_SS_FB1_HI], bank_q[PCR_OFF_SS_FB1_LO]};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_wr_at(logic [7:0] off);
        i_wr_en && !i_addr_load && (ptr_q == off);
    endsequence

    AST_PTR_STEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en || i_rd_en) && !i_addr_load |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("pointer did not step after a byte");

    AST_RD_BACK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_REF1) ##1 (i_addr_load && i_addr == PCR_OFF_REF1) ##1 rd_go
        |=> o_rd_valid && o_rd_data == $past(i_wr_data, 3))
        else $error("written byte did not read back");

    AST_UNMAPPED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        rd_go && !in_bank(ptr_q) |=> o_rd_valid && o_rd_data == 8'h00)
        else $error("unmapped byte did not read as zero");

    AST_DEFAULTS: assert property (@(posedge i_clk)
        $fell(i_sys_rst) |-> o_third_feedback_divider == 11'h1e0
        && o_first_feedback_divider == 11'h258 && o_first_ref_divider == 6'h19
        && o_out_divider_five == 4'h3 && o_first_channel_two_en && !o_first_ref_doubler)
        else $error("power-up values wrong");

    AST_OUT3_SRC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_PUMP3) |=> o_out_divider_three_src == $past(i_wr_data[7]))
        else $error("divider three source not taken from bit 7");

    AST_PUMP3: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_PUMP3)
        |-> ##2 o_third_pump_den == pump_den($past(i_wr_data[2], 2), $past(i_wr_data[1], 2)))
        else $error("third pump divisor wrong");

    AST_FB1_HIGH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_FILT1) |=> o_first_feedback_divider[10:8] == $past(i_wr_data[2:0]))
        else $error("first feedback high bits not from 0Ah");

    AST_CTRL1: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_CTRL1) |=> o_out_divider_five == $past(i_wr_data[3:0])
        && o_first_ref_doubler == $past(i_wr_data[7]))
        else $error("first control byte not applied");

    AST_SPREAD_LO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_SS_FB1_LO) |=> o_first_spread_fb_div[7:0] == $past(i_wr_data))
        else $error("spread feedback low byte not from 0Eh");

    AST_RES3: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_FILT3) |=> o_third_loop_res == $past(i_wr_data[7:4]))
        else $error("third loop resistors not from 05h");

    AST_ONLY3: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_FILT3) |=> o_third_loop_res_only == $past(i_wr_data[3]))
        else $error("third lone resistor not from 05h");

    AST_FB3_HIGH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_FILT3) |=> o_third_feedback_divider[10:8] == $past(i_wr_data[2:0]))
        else $error("third feedback high bits not from 05h");

    AST_FB3_LOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_FB3_LOW) |=> o_third_feedback_divider[7:0] == $past(i_wr_data))
        else $error("third feedback low byte not from 04h");

    AST_SIREF3: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_PUMP3) |=> o_third_ref_current_sel == $past(i_wr_data[0]))
        else $error("third reference current not from bit 0");

    // the product register trails the byte, so the answer is two edges out
    AST_PUMP3_NUM: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_PUMP3) |-> ##2 o_third_pump_num == ($past(i_wr_data[0], 2)
        ? {3'h0, $past(i_wr_data[6:3], 2), 1'b0} : {4'h0, $past(i_wr_data[6:3], 2)}))
        else $error("third pump multiplier wrong");

    AST_SIREF1: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_CTRL1) |=> o_first_ref_current_sel == $past(i_wr_data[6]))
        else $error("first reference current not from bit 6");

    AST_CH2_POLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_CTRL1)
        |=> {o_first_channel_two_en, o_first_third_pole_en} == $past(i_wr_data[5:4]))
        else $error("channel two or third pole not applied");

    AST_BYPASS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_REF1)
        |=> {o_first_ref_bypass_one, o_first_ref_bypass_two} == $past(i_wr_data[7:6]))
        else $error("reference bypass bits not applied");

    AST_MDIV: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_REF1) |=> o_first_ref_divider == $past(i_wr_data[5:0]))
        else $error("first reference divider not from 08h");

    AST_FB1_LOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_FB1_LOW) |=> o_first_feedback_divider[7:0] == $past(i_wr_data))
        else $error("first feedback low byte not from 09h");

    AST_FILT1: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_FILT1)
        |=> {o_first_loop_res, o_first_loop_res_only} == $past(i_wr_data[7:3]))
        else $error("first loop resistors not from 0Ah");

    AST_PUMP1_RAW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_PUMP1) |=> {o_first_pump_weights, o_first_pump_div24,
        o_first_pump_div3} == $past(i_wr_data))
        else $error("first pump bits not from 0Bh");

    // current select lives in another byte, so take it as the bank showed it
    AST_PUMP1_NUM: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_PUMP1) |-> ##2 o_first_pump_num == ($past(o_first_ref_current_sel)
        ? {1'b0, $past(i_wr_data[7:2], 2), 1'b0} : {2'b00, $past(i_wr_data[7:2], 2)}))
        else $error("first pump multiplier wrong");

    AST_SS_REF: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_SS_REF1)
        |=> {o_first_spread_ref_top_bit, o_first_spread_ref_div} == $past(i_wr_data))
        else $error("spread reference divider not from 0Ch");

    AST_SS_HI: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_wr_at(PCR_OFF_SS_FB1_HI) |=> o_first_spread_fb_div[15:8] == $past(i_wr_data))
        else $error("spread feedback high byte not from 0Dh");

endmodule

//--- bench/pcr_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// serial engine stand-in driving the byte port
// ----------------------------------------------------------------
module pcr_host_model (
    // clock
    input  wire logic       i_clk,
    // answers from the bank
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_data,
    // requests to the bank
    output logic            o_addr_load,
    output logic      [7:0] o_addr,
    output logic            o_wr_en,
    output logic      [7:0] o_wr_data,
    output logic            o_rd_en
);
    logic [7:0] got_q [$];
    int         valid_cnt;

    // quiet port at time zero
    initial begin
        o_addr_load = 1'b0;
        o_addr      = 8'h00;
        o_wr_en     = 1'b0;
        o_wr_data   = 8'h00;
        o_rd_en     = 1'b0;
    end

    task automatic point(input logic [7:0] a);
        o_addr_load = 1'b1;
        o_addr      = a;
        @(posedge i_clk);
        #1;
        o_addr_load = 1'b0;
        o_addr      = ~a; // released lines must not keep a stale match
    endtask

    // bytes back to back, strobe held across the burst
    task automatic write_seq(input logic [7:0] a, input logic [7:0] d [$]);
        point(a);
        o_wr_en = 1'b1;
        foreach (d[i]) begin
            o_wr_data = d[i];
            @(posedge i_clk);
            #1;
        end
        o_wr_en   = 1'b0;
        o_wr_data = ~o_wr_data;
    endtask

    // consecutive reads, each answer taken one cycle after its request
    task automatic read_seq(input logic [7:0] a, input int n);
        got_q.delete();
        valid_cnt = 0;
        point(a);
        o_rd_en = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            #1;
            if (i == n - 1) begin
                o_rd_en = 1'b0;
            end
            if (i_rd_valid === 1'b1) begin
                valid_cnt++;
            end
            got_q.push_back(i_rd_data);
        end
    endtask
endmodule

//--- bench/test_pll_config_register_bank.sv
`timescale 1ns/1ns
module test_pll_config_register_bank;
    logic        i_clk, i_sys_rst, i_addr_load, i_wr_en, i_rd_en, o_rd_valid;
    logic [7:0]  i_addr, i_wr_data, o_rd_data, o_reg_pointer;
    logic [3:0]  o_third_loop_res, o_third_pump_weights, o_out_divider_five;
    logic [3:0]  o_first_loop_res;
    logic [10:0] o_third_feedback_divider, o_first_feedback_divider;
    logic [7:0]  o_third_pump_num, o_third_pump_den, o_first_pump_num, o_first_pump_den;
    logic        o_third_loop_res_only, o_out_divider_three_src, o_third_pump_div24;
    logic        o_third_pump_div3, o_third_ref_current_sel, o_first_ref_doubler;
    logic        o_first_ref_current_sel, o_first_channel_two_en, o_first_third_pole_en;
    logic        o_first_ref_bypass_one, o_first_ref_bypass_two, o_first_loop_res_only;
    logic        o_first_pump_div24, o_first_pump_div3, o_first_spread_ref_top_bit;
    logic [5:0]  o_first_ref_divider, o_first_pump_weights;
    logic [6:0]  o_first_spread_ref_div;
    logic [15:0] o_first_spread_fb_div;
    int          num_errors = 0;
    int          n_tests = 0;
    logic [7:0]  cur [4:14];
    logic [7:0]  dflt [4:14] = '{8'he0, 8'h11, 8'h6c, 8'h23, 8'h19, 8'h58,
                                 8'hb2, 8'h06, 8'h00, 8'h00, 8'h00};

    pcr_bank pcr_bank_inst (.*);

    pcr_host_model pcr_host_model_inst (
        .i_clk(i_clk), .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data),
        .o_addr_load(i_addr_load), .o_addr(i_addr), .o_wr_en(i_wr_en),
        .o_wr_data(i_wr_data), .o_rd_en(i_rd_en));

    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ----------------------------------------------------------------
    // reporting
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // shared checks
    // ----------------------------------------------------------------
    // every field output against the bytes it comes from
    task automatic check_fields(input logic [7:0] b [4:14]);
        check(o_out_divider_three_src, b[6][7]);
        check(o_third_loop_res, b[5][7:4]);
        check(o_third_loop_res_only, b[5][3]);
        check(o_third_feedback_divider, {b[5][2:0], b[4]});
        check({o_third_pump_weights, o_third_pump_div24, o_third_pump_div3}, b[6][6:1]);
        check(o_third_ref_current_sel, b[6][0]);
        check(o_third_pump_num, (1 + b[6][0]) * b[6][6:3]);
        check(o_third_pump_den, 24 * b[6][2] + 3 * b[6][1]);
        check({o_first_ref_doubler, o_first_ref_current_sel}, b[7][7:6]);
        check({o_first_channel_two_en, o_first_third_pole_en}, b[7][5:4]);
        check(o_out_divider_five, b[7][3:0]);
        check({o_first_ref_bypass_one, o_first_ref_bypass_two}, b[8][7:6]);
        check(o_first_ref_divider, b[8][5:0]);
        check(o_first_feedback_divider, {b[10][2:0], b[9]});
        check({o_first_loop_res, o_first_loop_res_only}, b[10][7:3]);
        check({o_first_pump_weights, o_first_pump_div24, o_first_pump_div3}, b[11]);
        check(o_first_pump_num, (1 + b[7][6]) * b[11][7:2]);
        check(o_first_pump_den, 24 * b[11][1] + 3 * b[11][0]);
        check({o_first_spread_ref_top_bit, o_first_spread_ref_div}, b[12]);
        check(o_first_spread_fb_div, {b[13], b[14]});
    endtask

    // burst read compared byte by byte, then valid must drop
    task automatic cmp_read(input logic [7:0] a, input logic [7:0] e [$]);
        pcr_host_model_inst.read_seq(a, e.size());
        check(pcr_host_model_inst.valid_cnt, e.size());
        foreach (e[i]) check(pcr_host_model_inst.got_q[i], e[i]);
        check(o_reg_pointer, 8'(a + e.size()));
        @(posedge i_clk);
        #1;
        check(o_rd_valid, 1'b0);
    endtask

    // power-up state, read with an unmapped byte on each side
    task automatic check_defaults();
        logic [7:0] e [$];
        check(o_reg_pointer, 8'h00);
        check(o_rd_data, 8'h00);
        check_fields(dflt);
        e = {8'h00};
        for (int i = 4; i <= 14; i++) e.push_back(dflt[i]);
        e.push_back(8'h00);
        cmp_read(8'h03, e);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // whole bank written in one burst, once with a pattern, once inverted
    task automatic t_fields();
        logic [7:0] b [4:14];
        logic [7:0] e [$];
        for (int p = 0; p < 2; p++) begin
            e = {};
            for (int i = 4; i <= 14; i++) begin
                b[i] = 8'(i * 37) ^ {8{p[0]}} ^ 8'ha5;
                e.push_back(b[i]);
            end
            pcr_host_model_inst.write_seq(8'h04, e);
            check(o_reg_pointer, 8'h0f);
            @(posedge i_clk);
            #1;
            check_fields(b);
            cmp_read(8'h04, e);
        end
        cur = b;
    endtask

    // unmapped writes dropped, pointer wraps past ff
    task automatic t_unmapped();
        logic [7:0] e [$];
        e = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
        pcr_host_model_inst.write_seq(8'hfe, e);
        check(o_reg_pointer, 8'h04);
        check_fields(cur);
        e = {8'h3c, 8'hc3};
        pcr_host_model_inst.write_seq(8'h03, e);
        check(o_third_feedback_divider, {cur[5][2:0], 8'hc3});
        e = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc3, cur[5]};
        cmp_read(8'hff, e);
    endtask

    // one byte written, pointer reloaded, the same byte read straight back
    task automatic t_readback();
        logic [7:0] e [$];
        e = {8'h9d};
        pcr_host_model_inst.write_seq(8'h08, e);
        check({o_first_ref_bypass_one, o_first_ref_bypass_two}, 2'h2);
        check(o_first_ref_divider, 6'h1d);
        cmp_read(8'h08, e);
    endtask

    // reset in mid-run restores every default
    task automatic t_reset();
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        @(posedge i_clk);
        #1;
        check_defaults();
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        print_verdict();
    end

    // main sequence
    initial begin
        i_sys_rst = 1'b1;
        repeat (12) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        @(posedge i_clk);
        #1;
        check_defaults();
        t_fields();
        t_unmapped();
        t_readback();
        t_reset();
        print_verdict();
    end
endmodule
